// [accc_ctl.sv]
`timescale 1ns/1ns
`include "accc_defs.svh"

// Operation
// - All control register zero fields are taken together from one write strobe.
// - Four-bit input select is routed to the analog multiplexer.
// - Continuous select set repeats conversions back to back.
// - Reference level is a two-bit code split across two control registers.
// - Writing run bit one starts conversions with current settings.
// - First conversion takes 5129 cycles, plus 40 when power-up needed.
// - First completion clears run bit; it stays clear during continuous.
// - Interrupt request on first completion and every later one.
// - Later results follow every 256 cycles while continuous selected.
// - 13-bit result goes to high byte and low byte bits 7:3.
// - Clearing continuous select ends continuous conversion.
// - Disabled converter raises no new interrupts; pending one stays.
module accc_ctl #(
	parameter int FIFO_DEPTH = `ACCC_FIFO_DEPTH
) (
	input  wire logic                      clk,
	input  wire logic                      srst,
	input  wire logic                      ctl0_wr,
	input  wire accc_pkg::accc_ctl0_t      ctl0_wdata,
	input  wire logic                      ctl1_wr,
	input  wire logic                      ref_level_high_bit_in,
	input  wire logic [`ACCC_RESULT_W-1:0] conv_sample,
	input  wire logic                      irq_taken,
	output accc_pkg::accc_ctl0_t           ctl0_rdata,
	output logic                           ref_level_high_bit,
	output logic      [3:0]                analog_select,
	output logic                           ref_pin_drive,
	output logic      [1:0]                ref_level,
	output logic                           conv_power,
	output logic                           irq_req,
	output accc_pkg::accc_result_t         result,
	output logic                           result_valid,
	input  wire logic                      result_ready,
	output logic                           busy
);
	accc_pkg::accc_ctl0_t  ctl0_r;
	logic                  refh_r;
	accc_pkg::accc_state_t state_r;
	logic [12:0]           cnt_r;
	logic                  irq_r;
	logic                  powered_r;
	logic                  done;
	logic                  fifo_in_ready;
	accc_pkg::accc_result_t sample_fmt;
	logic                  converting;
	logic                  start_req;
	logic [12:0]           smp_s1_r;
	logic [12:0]           smp_s2_r;
	logic [12:0]           smp_s3_r;
	logic [12:0]           smp_r;
	logic [12:0]           gap_r;
	logic [12:0]           since_start_r;
	logic                  cold_start_r;
	logic                  stalled_r;

	assign ctl0_rdata         = ctl0_r;
	assign ref_level_high_bit = refh_r;
	assign analog_select      = ctl0_r.input_select;
	assign ref_level          = {refh_r, ctl0_r.ref_level_low_bit};
	assign ref_pin_drive      = ctl0_r.ref_output_enable;
	assign conv_power         = (state_r != accc_pkg::ACCC_IDLE);
	assign irq_req            = irq_r;
	assign busy               = conv_power;
	// Result layout with low pad bits zero
	assign sample_fmt = {smp_r, `ACCC_LOW_PAD_W'(0)};
	// A conversion is in progress; its counter runs, or holds at one while the buffer is full
	assign converting = (state_r == accc_pkg::ACCC_FIRST) || (state_r == accc_pkg::ACCC_CONTINUOUS_SELECT);
	// A completion occurs when the conversion counter expires and the result buffer has room
	assign done = converting && (cnt_r == 13'd1) && fifo_in_ready;
	// A run write that finds the sequencer idle
	assign start_req = (state_r == accc_pkg::ACCC_IDLE) && ctl0_wr && ctl0_wdata.conversion_run;

	// Control register zero: all fields in one write; hardware clears run
	always_ff @(posedge clk) begin
		if (srst) begin
			ctl0_r <= '0;
		end else if (ctl0_wr) begin
			ctl0_r <= ctl0_wdata;
		end else if (done && state_r == accc_pkg::ACCC_FIRST) begin
			ctl0_r.conversion_run <= 1'b0;
		end
	end

	// Control/status register one: reference level high bit
	always_ff @(posedge clk) begin
		if (srst) begin
			refh_r <= 1'b0;
		end else if (ctl1_wr) begin
			refh_r <= ref_level_high_bit_in;
		end
	end

	// Tracks whether converter was busy in the previous cycle with the reference level not off
	always_ff @(posedge clk) begin
		if (srst) begin
			powered_r <= 1'b0;
		end else begin
			powered_r <= (state_r != accc_pkg::ACCC_IDLE) && (ref_level != `ACCC_REF_OFF_CODE);
		end
	end

	// Conversion sequencer
	always_ff @(posedge clk) begin
		if (srst) begin
			state_r <= accc_pkg::ACCC_IDLE;
			cnt_r   <= '0;
		end else begin
			case (state_r)
				accc_pkg::ACCC_IDLE: begin
					if (ctl0_wr && ctl0_wdata.conversion_run) begin
						if (!powered_r) begin
							state_r <= accc_pkg::ACCC_POWERUP;
							cnt_r   <= `ACCC_POWERUP_CYC;
						end else begin
							state_r <= accc_pkg::ACCC_FIRST;
							cnt_r   <= `ACCC_FIRST_CONV_CYC;
						end
					end
				end
				accc_pkg::ACCC_POWERUP: begin
					if (cnt_r == 13'd1) begin
						state_r <= accc_pkg::ACCC_FIRST;
						cnt_r   <= `ACCC_FIRST_CONV_CYC;
					end else begin
						cnt_r <= cnt_r - 13'd1;
					end
				end
				accc_pkg::ACCC_FIRST, accc_pkg::ACCC_CONTINUOUS_SELECT: begin
					if (done) begin
						if (ctl0_r.continuous_select) begin
							state_r <= accc_pkg::ACCC_CONTINUOUS_SELECT;
							cnt_r   <= `ACCC_NEXT_CONV_CYC;
						end else begin
							state_r <= accc_pkg::ACCC_IDLE;
							cnt_r   <= '0;
						end
					end else if (cnt_r != 13'd1) begin
						cnt_r <= cnt_r - 13'd1;
					end
				end
				default: begin
					state_r <= accc_pkg::ACCC_IDLE;
					cnt_r   <= '0;
				end
			endcase
		end
	end

	// Completion interrupt: set wins over acknowledge, kept while idle
	always_ff @(posedge clk) begin
		if (srst) begin
			irq_r <= 1'b0;
		end else if (done) begin
			irq_r <= 1'b1;
		end else if (irq_taken) begin
			irq_r <= 1'b0;
		end
	end

	// Converter word passes three stages before use
	always_ff @(posedge clk) begin
		if (srst) begin
			smp_s1_r <= '0;
			smp_s2_r <= '0;
			smp_s3_r <= '0;
		end else begin
			smp_s1_r <= conv_sample;
			smp_s2_r <= smp_s1_r;
			smp_s3_r <= smp_s2_r;
		end
	end

	// Word is taken once the last two stages agree, so bit skew never leaks
	always_ff @(posedge clk) begin
		if (srst) begin
			smp_r <= '0;
		end else if (smp_s2_r == smp_s3_r) begin
			smp_r <= smp_s3_r;
		end
	end

	// Check helper: cycles since the last completion, saturating
	always_ff @(posedge clk) begin
		if (srst) begin
			gap_r <= '0;
		end else if (done) begin
			gap_r <= 13'd1;
		end else if (gap_r != 13'h1fff) begin
			gap_r <= gap_r + 13'd1;
		end
	end

	// Check helper: cycles since the run write that left idle
	always_ff @(posedge clk) begin
		if (srst) begin
			since_start_r <= '0;
			cold_start_r  <= 1'b0;
		end else if (start_req) begin
			since_start_r <= 13'd1;
			cold_start_r  <= !powered_r;
		end else if (since_start_r != 13'h1fff) begin
			since_start_r <= since_start_r + 13'd1;
		end
	end

	// Check helper: a completion held back by a full buffer
	always_ff @(posedge clk) begin
		if (srst) begin
			stalled_r <= 1'b0;
		end else if (done) begin
			stalled_r <= 1'b0;
		end else if (converting && cnt_r == 13'd1 && !fifo_in_ready) begin
			stalled_r <= 1'b1;
		end
	end

	// Result buffer; full stalls the sequencer
	accc_fifo #(
		.WIDTH (16),
		.DEPTH (FIFO_DEPTH),
		.AW    (`ACCC_FIFO_AW)
	) u_fifo (
		.clk       (clk),
		.srst      (srst),
		.in_data   (sample_fmt),
		.in_valid  (done),
		.in_ready  (fifo_in_ready),
		.out_data  (result),
		.out_valid (result_valid),
		.out_ready (result_ready)
	);

	// Assertions
	first_len_a: assert property (@(posedge clk) disable iff (srst)
		$rose(state_r == accc_pkg::ACCC_FIRST) |-> cnt_r == `ACCC_FIRST_CONV_CYC)
		else $error("first conversion length wrong");
	run_clear_a: assert property (@(posedge clk) disable iff (srst)
		(done && state_r == accc_pkg::ACCC_FIRST && !ctl0_wr) |=> !ctl0_r.conversion_run)
		else $error("run bit not cleared");
	irq_set_a: assert property (@(posedge clk) disable iff (srst)
		done |=> irq_r)
		else $error("no interrupt on completion");
	next_len_a: assert property (@(posedge clk) disable iff (srst)
		(done && ctl0_r.continuous_select) |=> cnt_r == `ACCC_NEXT_CONV_CYC)
		else $error("continuous period wrong");
	continuous_select_end_a: assert property (@(posedge clk) disable iff (srst)
		(done && !ctl0_r.continuous_select) |=> state_r == accc_pkg::ACCC_IDLE)
		else $error("conversion did not stop");
	idle_irq_a: assert property (@(posedge clk) disable iff (srst)
		(state_r == accc_pkg::ACCC_IDLE && !irq_r) |=> !irq_r)
		else $error("interrupt raised while idle");
	pwr_up_a: assert property (@(posedge clk) disable iff (srst)
		(state_r == accc_pkg::ACCC_IDLE && ctl0_wr && ctl0_wdata.conversion_run && powered_r)
		|=> state_r == accc_pkg::ACCC_FIRST)
		else $error("power-up added needlessly");
	ctl_take_a: assert property (@(posedge clk) disable iff (srst)
		ctl0_wr |=> ctl0_r == $past(ctl0_wdata))
		else $error("control fields not applied together");
	ref_code_a: assert property (@(posedge clk) disable iff (srst)
		ctl1_wr |=> ref_level[1] == $past(ref_level_high_bit_in))
		else $error("reference high bit wrong");
	// Timing seen from outside the counter, then counter load, range and stall hold checks
	first_abs_a: assert property (@(posedge clk) disable iff (srst)
		(done && state_r == accc_pkg::ACCC_FIRST && !stalled_r && cold_start_r)
		|-> since_start_r == `ACCC_FIRST_CONV_CYC + `ACCC_POWERUP_CYC)
		else $error("first conversion length wrong after power-up");

	warm_abs_a: assert property (@(posedge clk) disable iff (srst)
		(done && state_r == accc_pkg::ACCC_FIRST && !stalled_r && !cold_start_r)
		|-> since_start_r == `ACCC_FIRST_CONV_CYC)
		else $error("warm start took power-up time");

	gap_exact_a: assert property (@(posedge clk) disable iff (srst)
		(done && state_r == accc_pkg::ACCC_CONTINUOUS_SELECT && !stalled_r) |-> gap_r == `ACCC_NEXT_CONV_CYC)
		else $error("result spacing wrong");

	pwr_len_a: assert property (@(posedge clk) disable iff (srst)
		$rose(state_r == accc_pkg::ACCC_POWERUP) |-> cnt_r == `ACCC_POWERUP_CYC)
		else $error("power-up length wrong");

	cnt_bound_a: assert property (@(posedge clk) disable iff (srst)
		converting |-> (cnt_r != 13'd0) && (cnt_r <= `ACCC_FIRST_CONV_CYC))
		else $error("conversion counter out of range");

	stall_hold_a: assert property (@(posedge clk) disable iff (srst)
		(converting && cnt_r == 13'd1 && !fifo_in_ready)
		|=> (state_r == $past(state_r)) && (cnt_r == 13'd1))
		else $error("sequencer moved while buffer full");

	// Register, routing, sequencing and interrupt hold checks
	sel_route_a: assert property (@(posedge clk) disable iff (srst)
		ctl0_wr |=> analog_select == $past(ctl0_wdata.input_select))
		else $error("input select not routed");

	ref_pin_a: assert property (@(posedge clk) disable iff (srst)
		ctl0_wr |=> ref_pin_drive == $past(ctl0_wdata.ref_output_enable))
		else $error("reference pin drive wrong");

	ref_low_a: assert property (@(posedge clk) disable iff (srst)
		ctl0_wr |=> ref_level[0] == $past(ctl0_wdata.ref_level_low_bit))
		else $error("reference low bit wrong");

	start_a: assert property (@(posedge clk) disable iff (srst)
		start_req |=> state_r != accc_pkg::ACCC_IDLE)
		else $error("run write did not start");

	continuous_select_go_a: assert property (@(posedge clk) disable iff (srst)
		(done && ctl0_r.continuous_select) |=> state_r == accc_pkg::ACCC_CONTINUOUS_SELECT)
		else $error("continuous conversion did not repeat");

	run_stay_a: assert property (@(posedge clk) disable iff (srst)
		(state_r == accc_pkg::ACCC_CONTINUOUS_SELECT && !ctl0_r.conversion_run && !ctl0_wr)
		|=> !ctl0_r.conversion_run)
		else $error("run bit set again during continuous");

	irq_hold_a: assert property (@(posedge clk) disable iff (srst)
		(irq_r && !irq_taken) |=> irq_r)
		else $error("pending interrupt lost");

	// Result layout and converter word
	res_high_a: assert property (@(posedge clk) disable iff (srst)
		done |-> sample_fmt.result_high_byte == smp_r[12:5])
		else $error("result high byte misplaced");

	res_low_a: assert property (@(posedge clk) disable iff (srst)
		done |-> sample_fmt.result_low_byte == {smp_r[4:0], 3'h0})
		else $error("result low byte misplaced");

	smp_settle_a: assert property (@(posedge clk) disable iff (srst)
		(smp_s2_r == smp_s3_r) |=> smp_r == $past(smp_s3_r))
		else $error("settled converter word not taken");

	// Coverage of the main scenarios
	cov_first_c: cover property (@(posedge clk) disable iff (srst)
		done && state_r == accc_pkg::ACCC_FIRST);
	cov_continuous_select_c: cover property (@(posedge clk) disable iff (srst)
		done && state_r == accc_pkg::ACCC_CONTINUOUS_SELECT);
	cov_full_c: cover property (@(posedge clk) disable iff (srst) !fifo_in_ready);
	cov_warm_c: cover property (@(posedge clk) disable iff (srst)
		start_req && powered_r);
	cov_stop_c: cover property (@(posedge clk) disable iff (srst)
		done && state_r == accc_pkg::ACCC_CONTINUOUS_SELECT && !ctl0_r.continuous_select);
endmodule

// [accc_defs.svh]
`ifndef ACCC_DEFS_SVH
`define ACCC_DEFS_SVH

// Conversion timing in system clock cycles
`define ACCC_FIRST_CONV_CYC   13'd5129
`define ACCC_POWERUP_CYC      13'd40
`define ACCC_NEXT_CONV_CYC    13'd256
// Result layout
`define ACCC_RESULT_W         13
`define ACCC_LOW_PAD_W        3
// Reference level code meaning internal reference disabled
`define ACCC_REF_OFF_CODE     2'h0
// Result FIFO
`define ACCC_FIFO_DEPTH       32
`define ACCC_FIFO_AW          5

`endif

// [accc_fifo.sv]
`timescale 1ns/1ns
`include "accc_defs.svh"

module accc_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = `ACCC_FIFO_DEPTH,
	parameter int AW    = `ACCC_FIFO_AW
) (
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_r;
	logic [AW-1:0]    rd_r;
	logic [AW:0]      cnt_r;
	logic             push;
	logic             pop;

	// Honest full and empty from the fill count
	assign in_ready  = (cnt_r != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
	assign out_valid = (cnt_r != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rd_r];

	// Storage
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_r] <= in_data;
		end
	end

	// Pointers and count
	always_ff @(posedge clk) begin
		if (srst) begin
			wr_r  <= '0;
			rd_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
			end
			if (pop) begin
				rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
			end
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// [accc_irq_model.sv]
`timescale 1ns/1ns
module accc_irq_model #(
	parameter int LAT = 3
) (
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic irq_req,
	input  wire logic ack_en,
	output logic      irq_taken,
	output int        acks
);
	int wait_r;
	// Acknowledge a pending request after a short latency, one-cycle pulse
	always_ff @(posedge clk) begin
		if (srst) begin
			irq_taken <= 1'b0;
			wait_r <= 0;
			acks <= 0;
		end else begin
			irq_taken <= 1'b0;
			if (irq_req && ack_en && !irq_taken) begin
				if (wait_r == LAT) begin
					irq_taken <= 1'b1;
					wait_r <= 0;
					acks <= acks + 1;
				end else begin
					wait_r <= wait_r + 1;
				end
			end
		end
	end
endmodule

// [accc_pkg.sv]
package accc_pkg;

	// Control fields written together in one register write
	typedef struct packed {
		logic [3:0] input_select;
		logic       continuous_select;
		logic       ref_output_enable;
		logic       ref_level_low_bit;
		logic       conversion_run;
	} accc_ctl0_t;

	// Result bytes as seen by software
	typedef struct packed {
		logic [7:0] result_high_byte;
		logic [7:0] result_low_byte;
	} accc_result_t;

	typedef enum logic [1:0] {
		ACCC_IDLE    = 2'b00,
		ACCC_POWERUP = 2'b01,
		ACCC_FIRST   = 2'b10,
		ACCC_CONTINUOUS_SELECT    = 2'b11
	} accc_state_t;

endpackage

// [adc_continuous_conversion_ctl_tb.sv]
`timescale 1ns/1ns
module adc_continuous_conversion_ctl_tb;
	logic                   clk, srst, ctl0_wr, ctl1_wr, hb_in, irq_taken;
	logic                   result_ready, ack_en, irq_req, result_valid, busy;
	logic                   hb_out, ref_pin_drive, conv_power;
	logic [12:0]            sample;
	logic [3:0]             analog_select;
	logic [1:0]             ref_level;
	accc_pkg::accc_ctl0_t   w, rd;
	accc_pkg::accc_result_t result;
	int                     err_count, compares, acks, n;

	accc_ctl DUT (.clk(clk), .srst(srst), .ctl0_wr(ctl0_wr), .ctl0_wdata(w),
		.ctl1_wr(ctl1_wr), .ref_level_high_bit_in(hb_in), .conv_sample(sample),
		.irq_taken(irq_taken), .ctl0_rdata(rd), .ref_level_high_bit(hb_out),
		.analog_select(analog_select), .ref_pin_drive(ref_pin_drive),
		.ref_level(ref_level), .conv_power(conv_power), .irq_req(irq_req),
		.result(result), .result_valid(result_valid), .result_ready(result_ready),
		.busy(busy));
	accc_irq_model ICTL (.clk(clk), .srst(srst), .irq_req(irq_req), .ack_en(ack_en),
		.irq_taken(irq_taken), .acks(acks));

	// Clock, 100 ns period
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task chk(string nm, logic [15:0] got, logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			$display("[FAIL] %s exp %h got %h", nm, exp, got);
			err_count++;
		end
	endtask

	task step(int k);
		repeat (k) @(posedge clk);
		#10;
	endtask

	task wr0(logic [3:0] s, logic c, logic ro, logic lo, logic run);
		w = '{s, c, ro, lo, run};
		ctl0_wr = 1'b1;
		step(1);
		ctl0_wr = 1'b0;
	endtask

	// Cycles until the next rising irq_req
	task wait_rise();
		n = 0;
		while (irq_req === 1'b1 && n < 6000) begin
			step(1);
			n++;
		end
		while (irq_req !== 1'b1 && n < 6000) begin
			step(1);
			n++;
		end
	endtask

	task pop();
		result_ready = 1'b1;
		step(1);
		result_ready = 1'b0;
	endtask

	task test_start();
		hb_in = 1'b1;
		ctl1_wr = 1'b1;
		step(1);
		ctl1_wr = 1'b0;
		sample = 13'h1abc;
		wr0(4'ha, 1'b1, 1'b1, 1'b1, 1'b1);
		chk("sel", analog_select, 4'ha);
		chk("refpin", ref_pin_drive, 1'b1);
		chk("reflvl", ref_level, 2'h3);
		chk("busy", busy, 1'b1);
		chk("power", conv_power, 1'b1);
		chk("hbrd", hb_out, 1'b1);
		wait_rise();
		chk("first", n >= 5168 && n <= 5172, 1'b1);
		chk("run0", rd.conversion_run, 1'b0);
		chk("res1", result, {13'h1abc, 3'h0});
		pop();
		sample = 13'h0f0f;
		wait_rise();
		// Count starts one cycle late, after the pop
		chk("period", n + 1, 16'h0100);
		chk("res2", result, {13'h0f0f, 3'h0});
		chk("run0b", rd.conversion_run, 1'b0);
		pop();
	endtask

	task test_stop();
		wr0(4'ha, 1'b0, 1'b1, 1'b1, 1'b0);
		step(10);
		ack_en = 1'b0;
		n = 0;
		while (busy === 1'b1 && n < 300) begin
			step(1);
			n++;
		end
		chk("stopped", busy, 1'b0);
		step(600);
		chk("pend", irq_req, 1'b1);
		pop();
		step(600);
		chk("nonew", result_valid, 1'b0);
		ack_en = 1'b1;
		step(10);
		chk("acked", irq_req, 1'b0);
	endtask

	task test_fifo();
		int a0, k;
		a0 = acks;
		sample = 13'h1234;
		wr0(4'h3, 1'b1, 1'b0, 1'b1, 1'b1);
		step(5200 + 32 * 256 + 600);
		chk("full", acks - a0, 16'd32);
		chk("head", result, {13'h1234, 3'h0});
		wr0(4'h3, 1'b0, 1'b0, 1'b1, 1'b0);
		k = 0;
		result_ready = 1'b1;
		repeat (60) begin
			if (result_valid === 1'b1) k++;
			step(1);
		end
		result_ready = 1'b0;
		chk("drained", k, 16'd33);
		chk("idle", busy, 1'b0);
	endtask

	// Single conversion from cold, then a restart while still powered
	task test_warm();
		sample = 13'h1555;
		wr0(4'h5, 1'b0, 1'b0, 1'b1, 1'b1);
		wait_rise();
		chk("cold", n, 16'd5169);
		chk("single", busy, 1'b0);
		wr0(4'h5, 1'b0, 1'b0, 1'b1, 1'b1);
		wait_rise();
		chk("warm", n, 16'd5129);
		chk("res3", result, {13'h1555, 3'h0});
	endtask

	task end_of_test();
		$display("checks %0d errors %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Watchdog
	initial begin
		repeat (40000) @(posedge clk);
		err_count++;
		end_of_test();
	end

	// Main sequence
	initial begin
		err_count = 0;
		compares = 0;
		srst = 1'b1;
		ctl0_wr = 1'b0;
		ctl1_wr = 1'b0;
		hb_in = 1'b0;
		w = '0;
		sample = 13'h0;
		result_ready = 1'b0;
		ack_en = 1'b1;
		step(12);
		srst = 1'b0;
		test_start();
		test_stop();
		test_fifo();
		test_warm();
		end_of_test();
	end
endmodule
